// file: rtl/wdr_pkg.sv
// package of constants and types for the watchdog reset timer
// Behaviour
// - reset control register reloads on pin reset or standby, survives watchdog reset
// - watchdog overflow flag sets only on watchdog-mode overflow
// - watchdog flag clears only after being read set, then written zero
// - reset-enable zero: no chip reset, but counter and control reinitialised
// - reset-type bit picks power-on reset (0) or manual reset (1)
// - five low bits of reset control register read as one
// - shared write address: key 5a loads counter, key a5 loads control
// - key a5 with data 00 at reset register clears watchdog flag only
// - key 5a at reset register copies bits 6 and 5 into enable and type
// - byte reads: control at b8, counter at b9, reset register at bb
// - watchdog overflow drives overflow pin for 128 clock cycles
// - reset enabled: internal reset with overflow pin, lasting 512 cycles
// - pin reset beats watchdog reset and leaves watchdog flag cleared
// - interval-mode overflow sets interval flag and requests interrupt
// - standby is refused while timer enable is one
// - in standby after nmi, counting resumes; overflow ends standby
// - counter write in the same cycle as a count tick wins, tick dropped
// - clock select picks divide by 2,64,128,256,512,1024,4096,8192
// - counter clears on reset and while timer disabled outside the nmi wake from standby, and stops
`default_nettype none
package wdr_pkg;
  localparam logic [27:0] WDR_ADDR_CTRL = 28'h5ffffb8;
  localparam logic [27:0] WDR_ADDR_CNT = 28'h5ffffb9;
  localparam logic [27:0] WDR_ADDR_RST_W = 28'h5ffffba;
  localparam logic [27:0] WDR_ADDR_RST_R = 28'h5ffffbb;
  localparam logic [7:0] WDR_KEY_CNT = 8'h5a;
  localparam logic [7:0] WDR_KEY_CTRL = 8'ha5;
  localparam logic [7:0] WDR_CLR_DATA = 8'h00;
  localparam logic [7:0] WDR_CTRL_RST = 8'h18;
  localparam logic [7:0] WDR_RST_RST = 8'h1f;
  localparam logic [7:0] WDR_CNT_RST = 8'h00;
  localparam logic [7:0] WDR_CNT_MAX = 8'hff;
  localparam int WDR_B_OVF = 7;
  localparam int WDR_B_MODE = 6;
  localparam int WDR_B_TME = 5;
  localparam int WDR_B_RESET_ENABLE_BIT = 6;
  localparam int WDR_B_RESET_TYPE_SELECT = 5;
  localparam logic [7:0] WDR_CTRL_FIXED = 8'h18;
  localparam logic [7:0] WDR_RST_FIXED = 8'h1f;
  localparam int WDR_PIN_CYC = 128;
  localparam int WDR_IRST_CYC = 512;
  localparam int WDR_PRE_W = 13;
  localparam int WDR_PULSE_W = 10;
  typedef struct packed {
    logic wr;
    logic rd;
    logic word;
    logic [27:0] addr;
    logic [15:0] wdata;
  } wdr_bus_req_t;
  typedef struct packed {
    logic ovf_pin;
    logic int_rst;
    logic rst_manual;
  } wdr_rst_out_t;
endpackage
`default_nettype wire

// file: rtl/wdr_prescale.sv
// prescaler, held clear while counting is stopped, that yields a one-cycle count tick for the selected divide
`default_nettype none
module wdr_prescale
  import wdr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic [2:0] sel_i,
  output logic tick_o
);
  logic [WDR_PRE_W-1:0] div_r;

  // tap index for each clock select code
  function automatic int tap_of(input logic [2:0] s);
    case (s)
      3'h0: tap_of = 0;
      3'h1: tap_of = 5;
      3'h2: tap_of = 6;
      3'h3: tap_of = 7;
      3'h4: tap_of = 8;
      3'h5: tap_of = 9;
      3'h6: tap_of = 11;
      default: tap_of = 12;
    endcase
  endfunction

  // divider runs only while counting is allowed
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      div_r <= '0;
    end else if (ce_i) begin
      if (!run_i) begin
        div_r <= '0;
      end else begin
        div_r <= div_r + 1'b1;
      end
    end
  end

  // tick when all bits below and at the tap are ones
  always_comb begin
    logic [WDR_PRE_W-1:0] mask;
    mask = '0;
    for (int i = 0; i < WDR_PRE_W; i++) begin
      mask[i] = (i <= tap_of(sel_i));
    end
    tick_o = ce_i && run_i && ((div_r & mask) == mask);
  end
endmodule
`default_nettype wire

// file: rtl/wdr_pulse.sv
// fixed-length pulse stretcher started by a one-cycle trigger
`default_nettype none
module wdr_pulse
  import wdr_pkg::*;
#(
  parameter logic [WDR_PULSE_W-1:0] LEN = 10'h080
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic start_i,
  output logic active_o
);
  logic [WDR_PULSE_W-1:0] cnt_r;

  // load length on start, count down to zero
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      cnt_r <= '0;
    end else if (ce_i) begin
      if (start_i && cnt_r == '0) begin
        cnt_r <= LEN;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  assign active_o = (cnt_r != '0);
endmodule
`default_nettype wire

// file: rtl/wdr_watchdog.sv
// watchdog and interval timer with reset control, top level
`default_nettype none
module wdr_watchdog
  import wdr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire wdr_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  input wire logic standby_req_i,
  input wire logic nmi_i,
  output logic standby_o,
  output logic clock_run_o,
  output logic overflow_output_pin_b_o,
  output logic chip_reset_o,
  output logic reset_manual_o,
  output logic interval_interrupt_o
);
  typedef enum logic [1:0] {WDR_RUN, WDR_SLEEP, WDR_WAKE} wdr_state_t;

  logic [7:0] timer_count_r;
  logic [7:0] timer_control_status_r;
  logic watchdog_overflow_flag_r;
  logic reset_enable_bit_r;
  logic reset_type_select_r;
  logic ovf_seen_r;
  logic wflag_seen_r;
  logic [7:0] rdata_r;
  wdr_state_t state_r;
  logic tick;
  logic run;
  logic ovf;
  logic wd_ovf;
  logic it_ovf;
  logic cnt_wr;
  logic ctrl_wr;
  logic rclr_wr;
  logic rset_wr;
  logic pin_act;
  logic rst_act;
  logic timer_enable_bit;
  logic wt_mode;
  logic standby_entry;

  // decode a key-guarded word write
  function automatic logic key_hit(input wdr_bus_req_t b, input logic [27:0] a,
                                   input logic [7:0] k);
    key_hit = b.wr && b.word && b.addr == a && b.wdata[15:8] == k;
  endfunction

  assign timer_enable_bit = timer_control_status_r[WDR_B_TME];
  assign wt_mode = timer_control_status_r[WDR_B_MODE];

  // write strobes; byte writes and wrong keys hit nothing
  assign cnt_wr = ce_i && key_hit(bus_i, WDR_ADDR_CTRL, WDR_KEY_CNT);
  assign ctrl_wr = ce_i && key_hit(bus_i, WDR_ADDR_CTRL, WDR_KEY_CTRL);
  assign rclr_wr = ce_i && key_hit(bus_i, WDR_ADDR_RST_W, WDR_KEY_CTRL)
                   && bus_i.wdata[7:0] == WDR_CLR_DATA;
  assign rset_wr = ce_i && key_hit(bus_i, WDR_ADDR_RST_W, WDR_KEY_CNT);

  // counting is allowed when enabled, or while waking from standby
  assign run = timer_enable_bit || state_r == WDR_WAKE;

  wdr_prescale u_pre (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .run_i(run),
    .sel_i(timer_control_status_r[2:0]),
    .tick_o(tick)
  );

  // overflow when a tick lands on all ones and no write competes
  assign ovf = tick && !cnt_wr && timer_count_r == WDR_CNT_MAX;
  assign wd_ovf = ovf && timer_enable_bit && wt_mode && state_r == WDR_RUN;
  assign it_ovf = ovf && timer_enable_bit && !wt_mode && state_r == WDR_RUN;

  // timer count: held clear while disabled, a write wins over a tick
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      timer_count_r <= WDR_CNT_RST;
    end else if (ce_i) begin
      if (!run) begin
        timer_count_r <= WDR_CNT_RST;
      end else if (cnt_wr) begin
        timer_count_r <= bus_i.wdata[7:0];
      end else if (wd_ovf && !reset_enable_bit_r) begin
        timer_count_r <= WDR_CNT_RST;
      end else if (tick) begin
        timer_count_r <= timer_count_r + 1'b1;
      end
    end
  end

  // control register: interval flag sticky, set wins over clear
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      timer_control_status_r <= WDR_CTRL_RST;
    end else if (ce_i) begin
      if (standby_entry) begin
        timer_control_status_r <= {3'h0, WDR_CTRL_FIXED[4:3],
                                   timer_control_status_r[2:0]};
      end else if (wd_ovf) begin
        timer_control_status_r <= WDR_CTRL_RST;
      end else begin
        if (ctrl_wr) begin
          timer_control_status_r[6:0] <= {bus_i.wdata[6:5], WDR_CTRL_FIXED[4:3],
                                          bus_i.wdata[2:0]};
        end
        if (it_ovf) begin
          timer_control_status_r[WDR_B_OVF] <= 1'b1;
        end else if (ctrl_wr && !bus_i.wdata[WDR_B_OVF] && ovf_seen_r) begin
          timer_control_status_r[WDR_B_OVF] <= 1'b0;
        end
      end
    end
  end

  // remember interval flag read as one, for the read-then-clear order
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      ovf_seen_r <= 1'b0;
    end else if (ce_i) begin
      if (bus_i.rd && bus_i.addr == WDR_ADDR_CTRL) begin
        ovf_seen_r <= timer_control_status_r[WDR_B_OVF];
      end else if (ctrl_wr) begin
        ovf_seen_r <= 1'b0;
      end
    end
  end

  // reset control bits: pin reset and standby reload, watchdog reset does not
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || (ce_i && standby_entry)) begin
      watchdog_overflow_flag_r <= 1'b0;
      reset_enable_bit_r <= 1'b0;
      reset_type_select_r <= 1'b0;
    end else if (ce_i) begin
      if (wd_ovf) begin
        watchdog_overflow_flag_r <= 1'b1;
      end else if (rclr_wr && wflag_seen_r) begin
        watchdog_overflow_flag_r <= 1'b0;
      end
      if (rset_wr) begin
        reset_enable_bit_r <= bus_i.wdata[WDR_B_RESET_ENABLE_BIT];
        reset_type_select_r <= bus_i.wdata[WDR_B_RESET_TYPE_SELECT];
      end
    end
  end

  // remember watchdog flag read as one
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      wflag_seen_r <= 1'b0;
    end else if (ce_i) begin
      if (bus_i.rd && bus_i.addr == WDR_ADDR_RST_R) begin
        wflag_seen_r <= watchdog_overflow_flag_r;
      end else if (rclr_wr) begin
        wflag_seen_r <= 1'b0;
      end
    end
  end

  // read data register, byte reads only
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rdata_r <= 8'h00;
    end else if (ce_i && bus_i.rd) begin
      if (bus_i.word) begin
        rdata_r <= 8'h00;
      end else if (bus_i.addr == WDR_ADDR_CTRL) begin
        rdata_r <= timer_control_status_r | WDR_CTRL_FIXED;
      end else if (bus_i.addr == WDR_ADDR_CNT) begin
        rdata_r <= timer_count_r;
      end else if (bus_i.addr == WDR_ADDR_RST_R) begin
        rdata_r <= {watchdog_overflow_flag_r, reset_enable_bit_r,
                    reset_type_select_r, WDR_RST_FIXED[4:0]};
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  // standby sequencer: refuse entry while enabled, wake on nmi overflow
  assign standby_entry = state_r == WDR_RUN && standby_req_i && !timer_enable_bit;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state_r <= WDR_RUN;
    end else if (ce_i) begin
      case (state_r)
        WDR_RUN: begin
          if (standby_entry) begin
            state_r <= WDR_SLEEP;
          end
        end
        WDR_SLEEP: begin
          if (nmi_i) begin
            state_r <= WDR_WAKE;
          end
        end
        WDR_WAKE: begin
          if (ovf) begin
            state_r <= WDR_RUN;
          end
        end
        default: begin
          state_r <= WDR_RUN;
        end
      endcase
    end
  end

  // overflow pin pulse of 128 cycles
  wdr_pulse #(.LEN(10'(WDR_PIN_CYC))) u_pin (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .start_i(wd_ovf),
    .active_o(pin_act)
  );

  // internal reset pulse of 512 cycles, only when reset enabled
  wdr_pulse #(.LEN(10'(WDR_IRST_CYC))) u_rst (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .start_i(wd_ovf && reset_enable_bit_r),
    .active_o(rst_act)
  );

  // latch reset type at overflow so it holds through the pulse
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      reset_manual_o <= 1'b0;
    end else if (ce_i && wd_ovf) begin
      reset_manual_o <= reset_type_select_r;
    end
  end

  // outputs
  assign rdata_o = rdata_r;
  assign overflow_output_pin_b_o = !pin_act;
  assign chip_reset_o = rst_act;
  assign interval_interrupt_o = timer_control_status_r[WDR_B_OVF];
  assign standby_o = state_r != WDR_RUN;
  assign clock_run_o = state_r == WDR_RUN;
endmodule
`default_nettype wire

// file: sim/wdr_watchdog_monitor.sv
// checker of the watchdog reset timer outputs
`default_nettype none
module wdr_watchdog_monitor
  import wdr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic standby_req_i,
  input wire logic standby_o,
  input wire logic clock_run_o,
  input wire logic overflow_output_pin_b_o,
  input wire logic chip_reset_o,
  input wire logic reset_manual_o,
  input wire logic interval_interrupt_o
);
  logic [9:0] pin_n_r;
  logic [9:0] irst_n_r;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // cycles spent so far in the current pin pulse and chip reset pulse
  always_ff @(posedge ref_clk_i) begin
    pin_n_r <= (!rst_b_i || overflow_output_pin_b_o) ? 10'h000 : pin_n_r + 10'h001;
    irst_n_r <= (!rst_b_i || !chip_reset_o) ? 10'h000 : irst_n_r + 10'h001;
  end
  a_pin_width: assert property (
    $rose(overflow_output_pin_b_o) |-> pin_n_r == 10'h080) else $error("pin width");
  a_irst_width: assert property (
    $fell(chip_reset_o) |-> irst_n_r == 10'h200) else $error("chip reset width");
  a_irst_start: assert property (
    $rose(chip_reset_o) |-> $fell(overflow_output_pin_b_o)) else $error("reset start");
  a_manual_hold: assert property (
    chip_reset_o && $past(chip_reset_o) |-> $stable(reset_manual_o)) else $error("type moved");
  a_sleep_clk: assert property (
    standby_o |-> !clock_run_o) else $error("clock runs in standby");
  a_irq_pin: assert property (
    $rose(interval_interrupt_o) |-> !$fell(overflow_output_pin_b_o)) else $error("pin in interval");
  a_sleep_req: assert property (
    $rose(standby_o) |-> $past(standby_req_i) || $past(standby_req_i, 2)) else $error("sleep");
  a_wake_run: assert property (
    $fell(standby_o) |-> clock_run_o) else $error("wake without clock");
  // main scenarios reached
  c_pin: cover property ($fell(overflow_output_pin_b_o));
  c_irq: cover property ($rose(interval_interrupt_o));
  c_sleep: cover property ($rose(standby_o));
endmodule
bind wdr_watchdog wdr_watchdog_monitor mon_u (.ref_clk_i, .rst_b_i, .standby_req_i, .standby_o,
  .clock_run_o, .overflow_output_pin_b_o, .chip_reset_o, .reset_manual_o, .interval_interrupt_o);
`default_nettype wire

// file: sim/wdr_cpu_model.sv
// cpu side of the register bus: word or byte writes and byte reads
`default_nettype none
module wdr_cpu_model
  import wdr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic [7:0] rdata_i,
  output var wdr_bus_req_t bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus_o = '0;
  // one write, key in the upper byte; a released bus does not keep its value
  task automatic wr(input logic w, input logic [27:0] a, input logic [15:0] d);
    @(negedge ref_clk_i);
    bus_o = '{wr: 1'b1, rd: 1'b0, word: w, addr: a, wdata: d};
    @(negedge ref_clk_i);
    bus_o.wr = 1'b0;
    bus_o.addr = ~a;
    bus_o.wdata = ~d;
  endtask
  // one byte read, data taken the cycle after the request
  task automatic rd(input logic [27:0] a, output logic [7:0] v);
    @(negedge ref_clk_i);
    bus_o = '{wr: 1'b0, rd: 1'b1, word: 1'b0, addr: a, wdata: 16'h0000};
    @(negedge ref_clk_i);
    bus_o.rd = 1'b0;
    bus_o.addr = ~a;
    v = rdata_i;
  endtask
endmodule
`default_nettype wire

// file: sim/watchdog_reset_timer_bench.sv
// self-checking bench of the watchdog reset timer
`default_nettype none
module watchdog_reset_timer_bench import wdr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic w;
    logic [27:0] wa;
    logic [15:0] wd;
    logic [27:0] ra;
    logic [7:0] ex;
  } wdr_row_t;
  localparam logic [27:0] AC = WDR_ADDR_CTRL;
  localparam logic [27:0] AW = WDR_ADDR_RST_W;
  localparam logic [27:0] AR = WDR_ADDR_RST_R;
  // reset values, refused writes, field writes, unmapped read
  wdr_row_t rows [8] = '{
    '{1'b0, AC, 16'ha53f, AC, 8'h18},
    '{1'b0, AC, 16'h5a33, WDR_ADDR_CNT, 8'h00},
    '{1'b0, AW, 16'h5a7f, AR, 8'h1f},
    '{1'b1, AC, 16'h5a33, WDR_ADDR_CNT, 8'h00},
    '{1'b1, AC, 16'ha51f, AC, 8'h1f},
    '{1'b1, AW, 16'h5a7f, AR, 8'h7f},
    '{1'b1, AW, 16'h331f, AR, 8'h7f},
    '{1'b1, AW, 16'h5a1f, 28'h5ffffbc, 8'h00}
  };
  int divs [8] = '{2, 64, 128, 256, 512, 1024, 4096, 8192};
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic standby_req_i = 1'b0;
  logic nmi_i = 1'b0;
  logic ce_i = 1'b1;
  wdr_bus_req_t bus;
  logic [7:0] rdata;
  logic [7:0] v;
  logic sb, run, pin_b, crst, man, irq;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int n = 0;
  int m = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  wdr_watchdog dut_u (.ref_clk_i, .rst_b_i, .ce_i, .bus_i(bus), .rdata_o(rdata),
    .standby_req_i, .nmi_i, .standby_o(sb), .clock_run_o(run), .overflow_output_pin_b_o(pin_b),
    .chip_reset_o(crst), .reset_manual_o(man), .interval_interrupt_o(irq));
  wdr_cpu_model cpu_u (.ref_clk_i, .rdata_i(rdata), .bus_o(bus));
  task automatic report_and_stop;
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] ex);
    n_compared++;
    if (seen !== ex) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, ex);
    end
  endtask
  task automatic rdchk(input logic [27:0] a, input logic [7:0] ex);
    cpu_u.rd(a, v);
    chk(v, ex);
  endtask
  // wait for a level on an output, at most lim cycles, cycles waited in n
  task automatic wait_lvl(ref logic s, input logic l, input int lim);
    n = 0;
    while (s !== l && n < lim) begin
      @(negedge ref_clk_i);
      n++;
    end
  endtask
  // cut a hang short
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      report_and_stop;
    end
  end
  initial begin
    repeat (20) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    foreach (rows[i]) begin
      cpu_u.wr(rows[i].w, rows[i].wa, rows[i].wd);
      rdchk(rows[i].ra, rows[i].ex);
    end
    $display("rows done");
    // every clock select: two ticks from fe give an interval overflow
    for (int c = 0; c < 8; c++) begin
      cpu_u.wr(1'b1, AC, {WDR_KEY_CTRL, 5'h03, c[2:0]});
      cpu_u.wr(1'b1, AC, {WDR_KEY_CTRL, 5'h07, c[2:0]});
      cpu_u.wr(1'b1, AC, {WDR_KEY_CNT, 8'hfe});
      wait_lvl(irq, 1'b1, 20000);
      chk({7'h00, n >= divs[c] - 1 && n <= 2 * divs[c] + 2}, 8'h01);
      rdchk(AC, {5'h17, c[2:0]});
      rdchk(AR, 8'h1f);
      cpu_u.wr(1'b1, AC, {WDR_KEY_CTRL, 5'h03, c[2:0]});
      chk({7'h00, irq}, 8'h00);
    end
    // a counter write on either tick phase: exactly one read shows no increment
    cpu_u.wr(1'b1, AC, 16'ha538);
    for (int p = 0; p < 2; p++) begin
      repeat (p) @(negedge ref_clk_i);
      cpu_u.wr(1'b1, AC, 16'h5a80);
      cpu_u.rd(WDR_ADDR_CNT, v);
      m += (v === 8'h80);
    end
    chk(m[7:0], 8'h01);
    // clock enable low freezes counter and prescaler: two live edges give one tick
    cpu_u.rd(WDR_ADDR_CNT, v);
    m = v;
    ce_i = 1'b0;
    repeat (40) @(negedge ref_clk_i);
    ce_i = 1'b1;
    rdchk(WDR_ADDR_CNT, m[7:0] + 8'h01);
    $display("prescale done");
    // watchdog kept alive by rewrites, then left to overflow with reset off
    cpu_u.wr(1'b1, AW, 16'h5a3f);
    cpu_u.wr(1'b1, AC, 16'ha518);
    cpu_u.wr(1'b1, AC, 16'ha578);
    repeat (6) begin
      cpu_u.wr(1'b1, AC, 16'h5a00);
      wait_lvl(pin_b, 1'b0, 300);
      chk({7'h00, pin_b}, 8'h01);
    end
    cpu_u.wr(1'b1, AC, 16'h5afe);
    wait_lvl(pin_b, 1'b0, 20);
    chk({6'h00, pin_b, crst}, 8'h00);
    rdchk(AC, 8'h18);
    rdchk(WDR_ADDR_CNT, 8'h00);
    cpu_u.wr(1'b1, AW, 16'ha500);
    rdchk(AR, 8'hbf);
    cpu_u.wr(1'b1, AW, 16'ha500);
    rdchk(AR, 8'h3f);
    wait_lvl(pin_b, 1'b1, 200);
    chk({7'h00, pin_b}, 8'h01);
    $display("watchdog done");
    // reset enabled, both types; the pin reset lands inside the second one
    for (int s = 0; s < 2; s++) begin
      cpu_u.wr(1'b1, AW, {WDR_KEY_CNT, 2'h1, s[0], 5'h1f});
      cpu_u.wr(1'b1, AC, 16'ha578);
      cpu_u.wr(1'b1, AC, 16'h5afe);
      wait_lvl(pin_b, 1'b0, 20);
      chk({6'h00, crst, man}, {6'h01, s[0]});
      cpu_u.wr(1'b1, AC, 16'ha518);
      rdchk(AR, {2'h3, s[0], 5'h1f});
      if (s == 1) begin
        rst_b_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        rst_b_i = 1'b1;
      end else begin
        cpu_u.wr(1'b1, AW, 16'ha500);
      end
      rdchk(AR, s ? 8'h1f : 8'h5f);
      repeat (600) @(negedge ref_clk_i);
      chk({6'h00, pin_b, crst}, 8'h02);
    end
    $display("reset enable done");
    // standby refused while enabled, then entered and left through nmi
    cpu_u.wr(1'b1, AW, 16'h5a7f);
    cpu_u.wr(1'b1, AC, 16'ha538);
    standby_req_i = 1'b1;
    repeat (20) @(negedge ref_clk_i);
    chk({7'h00, sb}, 8'h00);
    cpu_u.wr(1'b1, AC, 16'ha518);
    wait_lvl(sb, 1'b1, 10);
    chk({6'h00, sb, run}, 8'h02);
    nmi_i = 1'b1;
    standby_req_i = 1'b0;
    @(negedge ref_clk_i);
    nmi_i = 1'b0;
    wait_lvl(run, 1'b1, 1000);
    chk({7'h00, n >= 480 && n <= 560}, 8'h01);
    rdchk(AR, 8'h1f);
    rdchk(AC, 8'h18);
    $display("standby done");
    report_and_stop;
  end
endmodule
`default_nettype wire
